//--- hdl/bwe_host.sv
`timescale 1ns/1ns
module bwe_host
  import bwe_pkg::*;
#(
  parameter int LOAD_WIN = LOAD_WIN_CYC,
  parameter int PROG_WAIT = PROG_CYC
)
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // request side
  input  wire logic                req_valid,
  input  wire bwe_pkg::bwe_req_t   req,
  output logic                     req_ready,
  output logic                     rd_valid,
  output logic [DATA_W-1:0]        rd_data,
  output logic                     page_err,
  output logic                     busy,
  // device pins
  output bwe_pkg::bwe_pins_t       pins,
  input  wire logic [DATA_W-1:0]   byte_bus_in,
  output logic [DATA_W-1:0]        byte_bus_out,
  output logic                     byte_bus_oe
);
  import bwe_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_SETUP, S_STROBE, S_RECOVER, S_PROG
  } bwe_state_t;

  bwe_state_t        state;
  bwe_op_t           cur_op;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  win;
  logic              in_page;
  logic [7:0]        loads;
  logic [ADDR_W-1:PAGE_LSB] page_tag;
  logic [DATA_W-1:0] bus_s1;
  logic [DATA_W-1:0] bus_s2;

  function automatic logic is_write(input bwe_op_t o);
    return o != BWE_OP_READ;
  endfunction

  // page loads must stay in page and under the byte limit
  logic page_ok;
  assign page_ok = !in_page ||
                   (req.addr[ADDR_W-1:PAGE_LSB] == page_tag &&
                    loads < 8'(PAGE_BYTES));

  // while programming, no request is taken at all; an expired page
  // commits first, and reads of this part wait until its page is
  // written, so only writes to the open page are served between loads
  assign req_ready = (state == S_IDLE) && !rst &&
                     !(in_page && win == '0) &&
                     (is_write(req.op) || !in_page);
  assign busy = (state != S_IDLE);

  // two flops on the returning bus before anything reads it
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      bus_s1 <= '0;
      bus_s2 <= '0;
    end
    else
    begin
      bus_s1 <= byte_bus_in;
      bus_s2 <= bus_s1;
    end

  // main sequencer
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      state <= S_IDLE;
      cur_op <= BWE_OP_READ;
      cnt <= '0;
      pins <= '{sel_n: 1'b1, gate_n: 1'b1, wstb_n: 1'b1, word_addr: '0};
      byte_bus_out <= '0;
      byte_bus_oe <= 1'b0;
    end
    else
    begin
      case (state)
        S_IDLE:
          // a page left open too long commits itself; wait out programming
          if (in_page && win == '0)
          begin
            state <= S_PROG;
            // the part's own window ends a margin after ours
            cnt <= CNT_W'(LOAD_MARGIN_CYC + PROG_WAIT);
          end
          else if (req_valid && req_ready &&
                   (!is_write(req.op) || page_ok))
          begin
            cur_op <= req.op;
            pins.word_addr <= req.addr;
            byte_bus_out <= req.data;
            byte_bus_oe <= is_write(req.op);
            pins.sel_n <= 1'b0;
            state <= S_SETUP;
            cnt <= CNT_W'(GAP_CYC);
          end
        S_SETUP:
          if (cnt <= 1)
          begin
            // select already low, so this edge is the later fall
            if (is_write(cur_op))
              pins.wstb_n <= 1'b0;
            else
              pins.gate_n <= 1'b0;
            state <= S_STROBE;
            cnt <= CNT_W'(STROBE_CYC);
          end
          else
            cnt <= cnt - 1'b1;
        S_STROBE:
          if (cnt <= 1)
          begin
            // strobe rises before select: it is the earlier rise
            pins.wstb_n <= 1'b1;
            pins.gate_n <= 1'b1;
            state <= S_RECOVER;
            cnt <= CNT_W'(GAP_CYC);
          end
          else
            cnt <= cnt - 1'b1;
        S_RECOVER:
          if (cnt <= 1)
          begin
            pins.sel_n <= 1'b1;
            byte_bus_oe <= 1'b0;
            if (cur_op == BWE_OP_BYTE || cur_op == BWE_OP_PAGE_LAST)
            begin
              state <= S_PROG;
              // the part waits out its load window before programming
              cnt <= CNT_W'(LOAD_WIN + PROG_WAIT);
            end
            else
              state <= S_IDLE;
          end
          else
            cnt <= cnt - 1'b1;
        S_PROG:
          if (cnt <= 1)
            state <= S_IDLE;
          else
            cnt <= cnt - 1'b1;
        default:
          state <= S_IDLE;
      endcase
    end

  // page bookkeeping and load window
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      in_page <= 1'b0;
      loads <= '0;
      page_tag <= '0;
      win <= '0;
    end
    else if (state == S_SETUP && cnt <= 1 && cur_op == BWE_OP_PAGE_LOAD)
    begin
      if (!in_page)
        page_tag <= pins.word_addr[ADDR_W-1:PAGE_LSB];
      in_page <= 1'b1;
      loads <= loads + 8'd1;
      // margin covers setup of the next load
      win <= CNT_W'(LOAD_WIN - LOAD_MARGIN_CYC);
    end
    else if (state == S_PROG || (state == S_SETUP && cnt <= 1 &&
             cur_op == BWE_OP_PAGE_LAST))
    begin
      in_page <= 1'b0;
      loads <= '0;
      win <= '0;
    end
    else if (win != '0)
      win <= win - 1'b1;

  // first recover cycle: two sync flops late, bus_s2 still holds a
  // level sampled while gate was low
  logic rd_take;
  assign rd_take = state == S_RECOVER && cnt == CNT_W'(GAP_CYC) &&
                   cur_op == BWE_OP_READ;

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      rd_valid <= 1'b0;
      rd_data <= '0;
      page_err <= 1'b0;
    end
    else
    begin
      rd_valid <= rd_take;
      if (rd_take)
        rd_data <= bus_s2;
      page_err <= req_ready && req_valid && is_write(req.op) && !page_ok;
    end

  // write strobe only with select low and gate high
  wr_gate_a: assert property (@(posedge clk) disable iff (rst)
    !pins.wstb_n |-> !pins.sel_n && pins.gate_n)
    else $error("write strobe without select or with gate low");

  // host drives bus never while gate low
  no_fight_a: assert property (@(posedge clk) disable iff (rst)
    !pins.gate_n |-> !byte_bus_oe)
    else $error("bus contention during read");

  sequence strobe_fall_s;
    $fell(pins.wstb_n);
  endsequence

  // strobe low long enough to pass noise filter
  wide_strobe_a: assert property (@(posedge clk) disable iff (rst)
    strobe_fall_s |-> !pins.wstb_n [*2])
    else $error("write strobe too short");

  // select held through whole strobe
  sel_hold_a: assert property (@(posedge clk) disable iff (rst)
    $rose(pins.sel_n) |-> $past(pins.wstb_n) && $past(pins.gate_n))
    else $error("select released during strobe");

  // no request accepted while programming
  prog_quiet_a: assert property (@(posedge clk) disable iff (rst)
    state == S_PROG |-> !req_ready && pins.wstb_n)
    else $error("access during programming");

  // open page never outlives the load window
  win_bound_a: assert property (@(posedge clk) disable iff (rst)
    in_page |-> win <= CNT_W'(LOAD_WIN))
    else $error("load window overrun");

  // loads in one page stay at or under the limit
  page_cap_a: assert property (@(posedge clk) disable iff (rst)
    loads <= 8'(PAGE_BYTES))
    else $error("too many page loads");

  // every page load after the first carries the page tag
  page_tag_a: assert property (@(posedge clk) disable iff (rst)
    strobe_fall_s and (in_page && loads > 1) |->
      pins.word_addr[ADDR_W-1:PAGE_LSB] == page_tag)
    else $error("page address changed mid page");

  // byte write always enters programming
  byte_prog_a: assert property (@(posedge clk) disable iff (rst)
    $rose(pins.sel_n) && cur_op == BWE_OP_BYTE |-> state == S_PROG)
    else $error("byte write did not start programming");

  // returned byte was sampled while gate was low
  read_window_a: assert property (@(posedge clk) disable iff (rst)
    rd_valid |-> !$past(pins.gate_n, 3))
    else $error("read data taken outside gate low");

endmodule

//--- hdl/bwe_pkg.sv
package bwe_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int PAGE_BYTES = 128;
  localparam int PAGE_LSB = 7;
  localparam int CLK_MHZ = 10;
  // strobe low time per access, in ns; must beat the noise filter
  localparam int STROBE_NS = 200;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  // setup / recovery around each strobe
  localparam int GAP_NS = 100;
  localparam int GAP_CYC = (GAP_NS * CLK_MHZ + 999) / 1000;
  // byte load window, in us; longest time rounds down
  localparam int LOAD_WIN_US = 100;
  localparam int LOAD_WIN_CYC = LOAD_WIN_US * CLK_MHZ;
  // safety margin taken off the load window
  localparam int LOAD_MARGIN_CYC = 50;
  // programming cycle time, in ms
  localparam int PROG_MS = 10;
  localparam int PROG_CYC = PROG_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 24;

  typedef enum logic [1:0] {
    BWE_OP_READ,
    BWE_OP_BYTE,
    BWE_OP_PAGE_LOAD,
    BWE_OP_PAGE_LAST
  } bwe_op_t;

  typedef struct packed {
    bwe_op_t             op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } bwe_req_t;

  typedef struct packed {
    logic                sel_n;
    logic                gate_n;
    logic                wstb_n;
    logic [ADDR_W-1:0]   word_addr;
  } bwe_pins_t;

endpackage

//--- tb/bwe_dev_model.sv
`timescale 1ns/1ns
module bwe_dev_model
  import bwe_pkg::*;
#(
  parameter int WIN  = 40,
  parameter int PROG = 20
)
(
  // timer clock
  input  wire logic               clk,
  // supply sense, high while supply is too low
  input  wire logic               supply_low,
  // device pins
  input  wire bwe_pkg::bwe_pins_t pins,
  input  wire logic [DATA_W-1:0]  bus,
  output logic                    drive,
  output logic [DATA_W-1:0]       dout
);
  import bwe_pkg::*;
  logic [DATA_W-1:0]        mem [0:(1<<ADDR_W)-1];
  logic [ADDR_W-1:0]        wa;
  logic [ADDR_W-PAGE_LSB-1:0] pg;
  logic                     ok = 1'b0;
  logic                     busy = 1'b0;
  int                       idle = 0;
  int                       loads = 0;
  time                      t0;
  wire wr_cond = !pins.sel_n && !pins.wstb_n && pins.gate_n;
  assign drive = !pins.sel_n && !pins.gate_n;
  assign dout = mem[pins.word_addr];
  // writes land at once; reads during programming are the host's risk
  always @(posedge wr_cond)
  begin
    t0 = $time;
    if (loads == 0) pg = pins.word_addr[ADDR_W-1:PAGE_LSB];
    ok = !busy && !supply_low && loads < PAGE_BYTES &&
         pg == pins.word_addr[ADDR_W-1:PAGE_LSB];
    wa = pins.word_addr;
    if (ok) idle = 0;
  end
  always @(negedge wr_cond)
    if (ok && $time - t0 >= 10)
    begin
      mem[wa] = bus;
      loads++;
    end
  always @(posedge clk)
    if (busy && ++idle >= PROG) busy = 0;
    else if (!busy && loads > 0 && ++idle >= WIN)
    begin
      busy = 1;
      idle = 0;
      loads = 0;
    end
endmodule

//--- tb/tb_bwe_host.sv
`timescale 1ns/1ns
module tb_bwe_host;
  import bwe_pkg::*;
  logic              clk = 0, rst = 1, req_valid = 0, supply_low = 0;
  bwe_req_t          req = '0;
  bwe_pins_t         pins;
  logic              req_ready, rd_valid, page_err, busy, oe, drv;
  logic [DATA_W-1:0] rd_data, hout, dout, d, last = '0;
  logic [ADDR_W-1:0] a, b;
  logic [8:0]        expq [$];
  logic [8:0]        e;
  int                num_errors = 0, total_checks = 0, seed = 87973;
  // released bus shows the inverse of its last level
  wire logic [DATA_W-1:0] bus = oe ? hout : drv ? dout : ~last;
  always #50 clk = ~clk;
  always @(posedge clk) last <= bus;
  bwe_host #(.LOAD_WIN(100), .PROG_WAIT(80)) uut (.clk(clk), .rst(rst),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .page_err(page_err),
    .busy(busy), .pins(pins), .byte_bus_in(bus), .byte_bus_out(hout),
    .byte_bus_oe(oe));
  // model window equals the host's LOAD_WIN: both stand for one window
  bwe_dev_model #(.WIN(100), .PROG(20)) dev (.clk(clk),
    .supply_low(supply_low), .pins(pins),
    .bus(bus), .drive(drv), .dout(dout));
  task automatic check(string n, logic [8:0] x, logic [8:0] y);
    total_checks++;
    if (x !== y)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, x, y);
    end
  endtask
  task automatic send(bwe_op_t op, logic [ADDR_W-1:0] ad,
                      logic [DATA_W-1:0] dt, logic err);
    if (err) expq.push_back(9'h100);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{op, ad, dt};
    do @(negedge clk); while (req_ready !== 1'b1);
    @(posedge clk);
    req_valid <= 1'b0;
  endtask
  task automatic rd(logic [ADDR_W-1:0] ad, logic [DATA_W-1:0] x);
    expq.push_back({1'b0, x});
    send(BWE_OP_READ, ad, 8'h00, 1'b0);
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(negedge clk)
  begin
    if (oe === 1'b1 && drv === 1'b1) check("bus_clash", 9'h0, 9'h1);
    if (rd_valid === 1'b1 || page_err === 1'b1)
    begin
      e = expq.size() > 0 ? expq.pop_front() : 9'h1FF;
      check("result", e, {page_err, page_err ? 8'h00 : rd_data});
    end
  end
  initial
  begin
    #(30000 * 100);
    num_errors++;
    report_and_stop();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (4)
    begin
      a = $random(seed);
      d = $random(seed);
      send(BWE_OP_BYTE, a, d, 1'b0);
      @(negedge clk);
      check("busy", 9'h001, 9'(busy));
      rd(a, d);
    end
    supply_low <= 1'b1;
    send(BWE_OP_BYTE, a, ~d, 1'b0);
    rd(a, d);
    supply_low <= 1'b0;
    a = $random(seed);
    a[6:0] = 7'h00;
    for (int i = 0; i < PAGE_BYTES; i++)
      send(BWE_OP_PAGE_LOAD, a + i, 8'(i) ^ 8'h5A, 1'b0);
    send(BWE_OP_PAGE_LOAD, a + 1, 8'hFF, 1'b1);
    rd(a, 8'h5A);
    rd(a + 127, 8'h25);
    b = a ^ 16'h4000;
    send(BWE_OP_PAGE_LOAD, b + 3, 8'hC3, 1'b0);
    send(BWE_OP_PAGE_LOAD, (b ^ 16'h0080) + 3, 8'h11, 1'b1);
    send(BWE_OP_PAGE_LAST, b + 5, 8'h3C, 1'b0);
    rd(b + 3, 8'hC3);
    rd(b + 5, 8'h3C);
    repeat (20) @(posedge clk);
    check("queue_left", 9'h0, 9'(expq.size()));
    report_and_stop();
  end
endmodule
